// file: hdl/reset_seq_pkg.sv
// Operation
// R1: Hard reset during power-up of domain 7 or 8-15 can hang that domain.
// R2: While hung, the reset-status output stays low.
// R3: Only full or power-on reset clears the hang; hard reset does not.
// R4: Host waits for reset-status to rise after a hard reset.
// R5: Host treats a stuck-low status as the hang and applies full reset.
// R6: Full or power-on reset re-latches the boot configuration pins.
// R7: System reset power-resets all cores and clears debug state and breakpoints.
// R8: Reset-status goes low on reset and stays low until the cycle completes.
// R9: Host uses a configurable timeout before escalating to full reset.
package reset_seq_pkg;

  // ==========================================================
  // Sizes and counts
  localparam int unsigned NUM_DOMAINS = 16;
  localparam int unsigned BOOT_WIDTH = 16;
  localparam int unsigned HANG_DOMAIN_LO = 7;
  localparam int unsigned HANG_DOMAIN_HI = 15;
  localparam int unsigned RESET_CYCLE_NS = 64;
  localparam int unsigned CLOCK_PERIOD_NS = 8;
  localparam int unsigned RESET_CYCLE_CYCLES = (RESET_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned DOMAIN_STEP_CYCLES = 4;

  // ==========================================================
  // Reset values
  localparam logic [NUM_DOMAINS-1:0] DOMAIN_ON_RESET = 16'h0001;
  localparam logic [BOOT_WIDTH-1:0] BOOT_CFG_RESET = 16'h0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic hard_reset_n;
    logic full_reset_n;
  } reset_pins_t;

  typedef struct packed {
    logic req;
    logic [3:0] domain;
  } power_up_req_t;

endpackage

// file: hdl/power_state_controller.sv
`timescale 1ns/1ps
module power_state_controller #(
  parameter int unsigned NUM_DOM = reset_seq_pkg::NUM_DOMAINS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic full_clear,
  input wire logic hard_reset_evt,
  input wire reset_seq_pkg::power_up_req_t pu_req,
  output logic [NUM_DOM-1:0] domain_on,
  output logic hung
);
  import reset_seq_pkg::*;

  typedef enum logic [1:0] {IDLE, RAMP, STUCK} psc_state_t;
  psc_state_t state_q;
  logic [3:0] dom_q;
  logic [2:0] step_q;

  function automatic logic hang_prone(input logic [3:0] d);
    hang_prone = (32'(d) >= HANG_DOMAIN_LO) && (32'(d) <= HANG_DOMAIN_HI);
  endfunction

  // ==========================================================
  // Domain transition state machine
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= IDLE;
      dom_q <= 4'h0;
      step_q <= 3'h0;
    end
    else if (full_clear)
    begin
      // R3: full clears hang
      state_q <= IDLE;
      step_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if (pu_req.req && !hard_reset_evt)
          begin
            state_q <= RAMP;
            dom_q <= pu_req.domain;
            step_q <= 3'h0;
          end
        end
        RAMP:
        begin
          // R1: hang on collision
          if (hard_reset_evt && hang_prone(dom_q))
            state_q <= STUCK;
          else if (hard_reset_evt)
            state_q <= IDLE;
          else if (32'(step_q) == DOMAIN_STEP_CYCLES - 1)
            state_q <= IDLE;
          else
            step_q <= step_q + 3'h1;
        end
        STUCK:
        begin
          // R3: hard reset does not clear
          state_q <= STUCK;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      domain_on <= DOMAIN_ON_RESET;
    else if (full_clear || hard_reset_evt)
      domain_on <= DOMAIN_ON_RESET;
    else if (state_q == RAMP && 32'(step_q) == DOMAIN_STEP_CYCLES - 1)
      domain_on[dom_q] <= 1'b1;
  end

  assign hung = (state_q == STUCK);

  // R3: hang survives hard reset
  a_hang_sticky: assert property (@(posedge clock) disable iff (!resetn)
    hung && !full_clear |=> hung) else $error("hang cleared without full reset");
  // R1: collision causes hang
  a_collision_hangs: assert property (@(posedge clock) disable iff (!resetn)
    state_q == RAMP && hard_reset_evt && hang_prone(dom_q) && !full_clear |=> hung)
    else $error("collision did not hang domain");
  c_hang_seen: cover property (@(posedge clock) disable iff (!resetn) $rose(hung));
endmodule

// file: hdl/hard_reset_hang_supervision.sv
`timescale 1ns/1ps
module hard_reset_hang_supervision #(
  parameter int unsigned NUM_DOM = reset_seq_pkg::NUM_DOMAINS,
  parameter int unsigned BOOT_W = reset_seq_pkg::BOOT_WIDTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hard_reset_n_in,
  input wire logic full_chip_reset_in,
  input wire logic [BOOT_W-1:0] boot_cfg_in,
  input wire reset_seq_pkg::power_up_req_t pu_req,
  output logic reset_done_status_out,
  output logic [BOOT_W-1:0] boot_cfg_latched,
  output logic [NUM_DOM-1:0] domain_on,
  output logic cores_power_reset,
  output logic debug_clear,
  output logic hang_flag
);
  import reset_seq_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] hard_sync_q;
  logic [1:0] full_sync_q;
  logic [BOOT_W-1:0] boot_s1_q;
  logic [BOOT_W-1:0] boot_s2_q;
  logic hard_prev_q;
  logic full_prev_q;
  logic hard_active;
  logic full_active;
  logic hard_evt;
  logic full_rise;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hard_sync_q <= 2'b11;
      full_sync_q <= 2'b00;
      boot_s1_q <= BOOT_CFG_RESET;
      boot_s2_q <= BOOT_CFG_RESET;
    end
    else
    begin
      hard_sync_q <= {hard_sync_q[0], hard_reset_n_in};
      full_sync_q <= {full_sync_q[0], full_chip_reset_in};
      boot_s1_q <= boot_cfg_in;
      boot_s2_q <= boot_s1_q;
    end
  end

  assign hard_active = !hard_sync_q[1];
  assign full_active = full_sync_q[1];

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      hard_prev_q <= 1'b0;
      full_prev_q <= 1'b0;
    end
    else
    begin
      hard_prev_q <= hard_active;
      full_prev_q <= full_active;
    end
  end

  assign hard_evt = hard_active && !hard_prev_q;
  assign full_rise = full_active && !full_prev_q;

  // ==========================================================
  // Power state controller
  logic hung;
  logic [NUM_DOM-1:0] dom_on;

  power_state_controller #(
    .NUM_DOM(NUM_DOM)
  ) u_psc (
    .clock(clock),
    .resetn(resetn),
    .full_clear(full_active),
    .hard_reset_evt(hard_evt),
    .pu_req(pu_req),
    .domain_on(dom_on),
    .hung(hung)
  );

  // ==========================================================
  // Reset cycle sequencing
  logic [7:0] cycle_cnt_q;
  logic in_reset_q;
  logic first_boot_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cycle_cnt_q <= 8'h00;
      in_reset_q <= 1'b1;
    end
    // R8: hold low during reset
    else if (hard_active || full_active)
    begin
      cycle_cnt_q <= 8'h00;
      in_reset_q <= 1'b1;
    end
    else if (in_reset_q && !hung)
    begin
      if (32'(cycle_cnt_q) == RESET_CYCLE_CYCLES - 1)
        in_reset_q <= 1'b0;
      else
        cycle_cnt_q <= cycle_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reset_done_status_out <= 1'b0;
    else
      // R2: stuck low while hung
      reset_done_status_out <= !in_reset_q && !hung && !hard_active && !full_active;
  end

  // ==========================================================
  // Boot configuration latch
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_cfg_latched <= BOOT_CFG_RESET;
      first_boot_q <= 1'b1;
    end
    else
    begin
      // Latch through power-on cycle, pins settle after two edges
      first_boot_q <= first_boot_q && in_reset_q;
      // R6: re-latch on full reset
      if (full_active || first_boot_q)
        boot_cfg_latched <= boot_s2_q;
    end
  end

  // ==========================================================
  // Core power and debug clear
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cores_power_reset <= 1'b1;
      debug_clear <= 1'b1;
    end
    else
    begin
      // R7: system reset clears cores
      cores_power_reset <= hard_active || full_active;
      debug_clear <= hard_evt || full_rise;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      domain_on <= DOMAIN_ON_RESET;
      hang_flag <= 1'b0;
    end
    else
    begin
      domain_on <= dom_on;
      hang_flag <= hung;
    end
  end

  // ==========================================================
  // Assertions
  a_status_low_hung: assert property (@(posedge clock) disable iff (!resetn) // R2
    hung |=> !reset_done_status_out) else $error("status high while hung");
  a_status_low_reset: assert property (@(posedge clock) disable iff (!resetn) // R8
    hard_active |=> !reset_done_status_out) else $error("status high during reset");
  a_full_relatch: assert property (@(posedge clock) disable iff (!resetn) // R6
    full_active |=> boot_cfg_latched == $past(boot_s2_q)) else $error("boot pins not latched");
  a_core_reset: assert property (@(posedge clock) disable iff (!resetn) // R7
    hard_evt |=> cores_power_reset && debug_clear) else $error("cores not reset");
  a_hard_keeps_hang: assert property (@(posedge clock) disable iff (!resetn) // R3
    hung && !full_active |=> hung) else $error("hang left without full reset");
  a_status_release: assert property (@(posedge clock) disable iff (!resetn) // R8
    $fell(hard_active) && !hung && !full_active ##1 (!hard_active && !full_active && !hung) [*8]
    |=> reset_done_status_out) else $error("status did not rise");
  a_hang_flag: assert property (@(posedge clock) disable iff (!resetn) // R1
    $rose(hung) |=> hang_flag) else $error("hang flag missing");
  a_full_recover: assert property (@(posedge clock) disable iff (!resetn) // R3
    hung && full_active |=> !hung) else $error("full reset did not recover");
  c_normal_release: cover property (@(posedge clock) disable iff (!resetn) $rose(reset_done_status_out));
  c_hang: cover property (@(posedge clock) disable iff (!resetn) $rose(hang_flag));
  c_recover: cover property (@(posedge clock) disable iff (!resetn) $fell(hang_flag));
endmodule

// file: tb/host_reset_model.sv
`timescale 1ns/1ps
// ====================
// Host reset controller
module host_reset_model #(
  parameter int unsigned TIMEOUT = 40
) (
  input wire logic clock,
  input wire logic go,
  input wire logic status,
  input wire logic [15:0] cfg,
  output logic hard_n,
  output logic full,
  output logic [15:0] boot,
  output logic escalated,
  output logic busy
);
  task automatic apply(input logic use_full, output logic ok);
    int i;
    if (use_full)
      full = 1'b1;
    else
      hard_n = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    full = 1'b0;
    hard_n = 1'b1;
    ok = 1'b0;
    for (i = 0; i < TIMEOUT && !ok; i++)
    begin
      @(posedge clock);
      #1;
      ok = (status === 1'b1);
    end
  endtask

  initial
  begin
    hard_n = 1'b1;
    full = 1'b0;
    boot = cfg;
    escalated = 1'b0;
    busy = 1'b0;
  end

  always @(posedge go)
  begin : sequence_run
    logic ok;
    busy = 1'b1;
    escalated = 1'b0;
    apply(1'b0, ok);
    if (!ok)
      apply(1'b0, ok);
    // stuck low, escalate to full reset
    if (!ok)
    begin
      escalated = 1'b1;
      // valid boot levels during full reset
      boot = cfg;
      apply(1'b1, ok);
    end
    busy = 1'b0;
  end
endmodule

// file: tb/tb_hard_reset_hang_supervision.sv
`timescale 1ns/1ps
module tb_hard_reset_hang_supervision;
  import reset_seq_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic go = 1'b0;
  logic [15:0] cfg = 16'h5a3c;
  logic [15:0] exp_boot = 16'h5a3c;
  power_up_req_t pu_req = '0;
  logic hard_n, full, status, cpr, dbg, hang, escalated, busy;
  logic [15:0] boot, latched, dom;
  logic hang_seen, dbg_seen, cpr_seen, low_seen;
  int fails = 0;
  int total_checks = 0;
  int k;

  initial
  begin
    forever #4 clock = ~clock;
  end

  hard_reset_hang_supervision u_hard_reset_hang_supervision (.clock(clock), .resetn(resetn),
    .hard_reset_n_in(hard_n), .full_chip_reset_in(full), .boot_cfg_in(boot), .pu_req(pu_req),
    .reset_done_status_out(status), .boot_cfg_latched(latched), .domain_on(dom),
    .cores_power_reset(cpr), .debug_clear(dbg), .hang_flag(hang));

  host_reset_model u_host_reset_model (.clock(clock), .go(go), .status(status), .cfg(cfg),
    .hard_n(hard_n), .full(full), .boot(boot), .escalated(escalated), .busy(busy));

  // ====================
  // Compare and verdict
  task automatic check_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic will_hang(input int dm);
    return dm >= int'(HANG_DOMAIN_LO) && dm <= int'(HANG_DOMAIN_HI);
  endfunction

  // ====================
  // Monitor
  always @(negedge clock)
  begin
    hang_seen = hang_seen | (hang === 1'b1);
    dbg_seen = dbg_seen | (dbg === 1'b1);
    cpr_seen = cpr_seen | (cpr === 1'b1);
    low_seen = low_seen | (busy && status === 1'b0);
    if (hang === 1'b1)
      check_bit(status, 1'b0, "status high while hung");
  end

  // ====================
  // One reset sequence, optional power-up first
  task automatic run(input int dm);
    int i;
    logic hung;
    cfg = 16'($urandom);
    hang_seen = 1'b0;
    dbg_seen = 1'b0;
    cpr_seen = 1'b0;
    low_seen = 1'b0;
    hung = dm >= 0 && will_hang(dm);
    pu_req.req = (dm >= 0);
    pu_req.domain = 4'(dm);
    @(posedge clock);
    #1;
    pu_req = '0;
    go = 1'b1;
    @(posedge clock);
    #1;
    go = 1'b0;
    for (i = 0; i < 600 && busy !== 1'b0; i++)
      @(posedge clock);
    if (busy !== 1'b0)
    begin
      fails++;
      $display("unexpected at %0t: host sequence hung", $time);
      give_verdict();
    end
    #1;
    if (hung)
      exp_boot = cfg;
    check_bit(hang_seen, hung, "hang flag");
    check_bit(escalated, hung, "escalation");
    check_bit(dbg_seen, 1'b1, "debug clear");
    check_bit(cpr_seen, 1'b1, "cores power reset");
    check_bit(low_seen, 1'b1, "status low in reset");
    check_bit(status, 1'b1, "status after sequence");
    check_bit(hang, 1'b0, "hang after sequence");
    check_vec(latched, exp_boot, "boot latch");
    check_vec(dom, DOMAIN_ON_RESET, "domains after reset");
  endtask

  initial
  begin
    void'($urandom(43));
    repeat (20) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check_vec(latched, exp_boot, "boot at power-on");
    // Ramp completes undisturbed
    pu_req.req = 1'b1;
    pu_req.domain = 4'h3;
    @(posedge clock);
    #1;
    pu_req = '0;
    repeat (8) @(posedge clock);
    #1;
    check_vec(dom, DOMAIN_ON_RESET | 16'h0008, "domain powered");
    run(-1);
    run(6);
    run(7);
    run(15);
    run(8);
    for (k = 0; k < 6; k++)
      run(int'($urandom_range(15, 0)));
    give_verdict();
  end
endmodule
